/* File: hw/dcg_clock_gate.sv */
// Deep-sleep unit clock gate register with bus fault detection
// Operation
// - Each writable bit clocks one unit
// - Access to gated unit raises bus fault
// - Reset clears every register bit to zero
// - Sleep registers need automatic gating select set
// - Bit 30 enables Ethernet PHY clock
// - Bit 28 enables Ethernet MAC clock
// - Bits 6..0 enable ports G..A
// - Reserved bits read zero, software preserves
//
// Our own choice: the Wishbone interface to the registers.
module dcg_clock_gate (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [dcg_pkg::ADDR_W-1:0] adr_i,
    input wire logic [dcg_pkg::SEL_W-1:0] sel_i,
    input wire logic [dcg_pkg::DATA_W-1:0] dat_i,
    output logic [dcg_pkg::DATA_W-1:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // Power management context
    input wire logic [31:0] run_gate_i,
    input wire logic [31:0] sleep_gate_i,
    input wire logic auto_gating_select_i,
    input wire logic [1:0] pwr_state_i,
    // Unit side
    output logic [31:0] unit_clk_en_o,
    input wire logic [31:0] unit_req_i,
    output logic [31:0] bus_fault_o,
    // Interrupt
    output logic irq_o
);
    // Register state
    logic [31:0] deep_gate_ff;   // Deep-sleep gate word
    logic [31:0] fault_stat_ff;  // Sticky fault flags
    logic [31:0] fault_mask_ff;  // Interrupt mask
    logic [31:0] fault_ff;       // Fault answer to units
    logic [31:0] dat_ff;         // Read data
    logic ack_ff;
    logic err_ff;
    // Bus decode
    logic req;
    logic hit;
    logic wr_now;
    logic [31:0] bmask;          // Byte enables as bit mask
    logic [31:0] rd_word;
    logic [31:0] fault_set;

    dcg_sel_if sel_if ();

    // Byte lane expansion, one lane per step
    genvar g;
    generate
        for (g = 0; g < dcg_pkg::SEL_W; g++) begin : g_lane
            assign bmask[g*8 +: 8] = {8{sel_i[g]}};
        end
    endgenerate

    // A new request is seen only while no answer stands
    assign req = cyc_i && stb_i && !ack_ff && !err_ff;
    assign hit = (adr_i == dcg_pkg::OFS_DEEP_GATE) || (adr_i == dcg_pkg::OFS_FAULT_STAT)
              || (adr_i == dcg_pkg::OFS_FAULT_MASK) || (adr_i == dcg_pkg::OFS_CLK_EN);
    // Writes land on the edge where the master samples ack
    assign wr_now = ack_ff && we_i;

    // Answer: ack for mapped offsets, err for anything else
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            ack_ff <= req && hit;
            err_ff <= req && !hit;
        end
    end

    // Read mux; reserved positions return zero
    always_comb begin
        rd_word = dcg_pkg::ZERO_WORD;
        unique case (adr_i)
            dcg_pkg::OFS_DEEP_GATE: rd_word = deep_gate_ff & dcg_pkg::GATE_WR_MASK;
            dcg_pkg::OFS_FAULT_STAT: rd_word = fault_stat_ff;
            dcg_pkg::OFS_FAULT_MASK: rd_word = fault_mask_ff;
            dcg_pkg::OFS_CLK_EN: rd_word = sel_if.clk_en;
            default: rd_word = dcg_pkg::ZERO_WORD;
        endcase
    end

    // Read data captured with the answer and held until release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= dcg_pkg::ZERO_WORD;
        end else if (req && hit && !we_i) begin
            dat_ff <= rd_word;
        end
    end

    // Deep-sleep gate word; only documented bits can be written
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            deep_gate_ff <= dcg_pkg::GATE_RESET;
        end else if (wr_now && adr_i == dcg_pkg::OFS_DEEP_GATE) begin
            // Reserved positions never take a write
            deep_gate_ff <= (deep_gate_ff & ~(bmask & dcg_pkg::GATE_WR_MASK))
                          | (dat_i & bmask & dcg_pkg::GATE_WR_MASK);
        end
    end

    // Interrupt mask, same layout as the gate word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_mask_ff <= dcg_pkg::GATE_RESET;
        end else if (wr_now && adr_i == dcg_pkg::OFS_FAULT_MASK) begin
            fault_mask_ff <= (fault_mask_ff & ~(bmask & dcg_pkg::GATE_WR_MASK))
                           | (dat_i & bmask & dcg_pkg::GATE_WR_MASK);
        end
    end

    // A unit access while its clock is off is refused with a fault
    assign fault_set = unit_req_i & ~sel_if.clk_en & dcg_pkg::GATE_WR_MASK;

    // Fault answer repeats the gated request one cycle later, per unit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_ff <= dcg_pkg::ZERO_WORD;
        end else begin
            fault_ff <= fault_set;
        end
    end

    // Sticky status: write one clears, a new fault wins over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_stat_ff <= dcg_pkg::ZERO_WORD;
        end else if (wr_now && adr_i == dcg_pkg::OFS_FAULT_STAT) begin
            fault_stat_ff <= (fault_stat_ff & ~(dat_i & bmask)) | fault_ff;
        end else begin
            fault_stat_ff <= fault_stat_ff | fault_ff;
        end
    end

    // Selector inputs; the other two gate words live outside
    assign sel_if.run_gate = run_gate_i;
    assign sel_if.sleep_gate = sleep_gate_i;
    assign sel_if.deep_gate = deep_gate_ff;
    assign sel_if.auto_sel = auto_gating_select_i;
    assign sel_if.state = pwr_state_i;

    // Enable selector with registered, glitch-free output
    dcg_gate_sel u_sel (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_if(sel_if.sel)
    );

    // Outputs
    assign unit_clk_en_o = sel_if.clk_en;
    assign bus_fault_o = fault_ff;
    assign dat_o = dat_ff;
    assign ack_o = ack_ff;
    assign err_o = err_ff;
    assign irq_o = |(fault_stat_ff & fault_mask_ff);

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Reset leaves every gate bit clear
    a_reset_gate_clear: assert property ($fell(rst_i) |-> deep_gate_ff == '0 && unit_clk_en_o == '0)
        else $error("gate bits not clear after reset");
    // Reserved gate bits never become set
    a_resv_bits_zero: assert property ((deep_gate_ff & ~dcg_pkg::GATE_WR_MASK) == '0)
        else $error("reserved gate bit set");
    // Full write reaches the PHY bit
    a_phy_bit_write: assert property (ack_o && we_i && adr_i == dcg_pkg::OFS_DEEP_GATE && sel_i[3]
        |=> deep_gate_ff[dcg_pkg::PHY_BIT] == $past(dat_i[dcg_pkg::PHY_BIT]))
        else $error("phy enable bit not written");
    // Full write reaches the MAC bit
    a_mac_bit_write: assert property (ack_o && we_i && adr_i == dcg_pkg::OFS_DEEP_GATE && sel_i[3]
        |=> deep_gate_ff[dcg_pkg::MAC_BIT] == $past(dat_i[dcg_pkg::MAC_BIT]))
        else $error("mac enable bit not written");
    // Port bits follow a low-lane write
    a_port_bits_write: assert property (ack_o && we_i && adr_i == dcg_pkg::OFS_DEEP_GATE && sel_i[0]
        |=> deep_gate_ff[dcg_pkg::PORT_HI:dcg_pkg::PORT_LO]
            == $past(dat_i[dcg_pkg::PORT_HI:dcg_pkg::PORT_LO]))
        else $error("port enable bits not written");
    // Deep-sleep word governs enables one cycle later
    a_deep_select: assert property (auto_gating_select_i && pwr_state_i == 2'(dcg_pkg::PWR_DEEP)
        |=> unit_clk_en_o == $past(deep_gate_ff))
        else $error("deep-sleep enables not applied");
    // Without automatic gating only the run word counts
    a_no_auto_run: assert property (!auto_gating_select_i
        |=> unit_clk_en_o == ($past(run_gate_i) & dcg_pkg::GATE_WR_MASK))
        else $error("run enables not applied");
    // Access to a gated unit answers with a fault pulse
    a_fault_gated: assert property (|(unit_req_i & ~unit_clk_en_o & dcg_pkg::GATE_WR_MASK)
        |=> |bus_fault_o ##1 (fault_stat_ff != '0))
        else $error("gated access without fault");
    // Access to a clocked unit never faults
    a_clocked_ok: assert property (unit_req_i == (unit_req_i & unit_clk_en_o)
        |=> bus_fault_o == '0)
        else $error("fault on clocked unit");
    // Enables only move on a clock edge and stay in writable bits
    a_en_legal: assert property ($changed(unit_clk_en_o)
        |-> (unit_clk_en_o & ~dcg_pkg::GATE_WR_MASK) == '0)
        else $error("enable on reserved position");
    // An ack answer stands one cycle
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");


    // Bus answer checks: one answer kind per request, in the slot after it is taken
    // A mapped request is answered by ack on the next edge
    a_ack_in_slot: assert property (cyc_i && stb_i && !ack_o && !err_o
        && (adr_i == dcg_pkg::OFS_DEEP_GATE || adr_i == dcg_pkg::OFS_FAULT_STAT
            || adr_i == dcg_pkg::OFS_FAULT_MASK || adr_i == dcg_pkg::OFS_CLK_EN)
        |=> ack_o && !err_o)
        else $error("mapped request not acknowledged");
    // An unmapped request is refused with err on the next edge
    a_err_in_slot: assert property (cyc_i && stb_i && !ack_o && !err_o
        && adr_i != dcg_pkg::OFS_DEEP_GATE && adr_i != dcg_pkg::OFS_FAULT_STAT
        && adr_i != dcg_pkg::OFS_FAULT_MASK && adr_i != dcg_pkg::OFS_CLK_EN
        |=> err_o && !ack_o)
        else $error("unmapped request not refused");
    // The error answer also stands one cycle only
    a_err_single: assert property (err_o |=> !err_o)
        else $error("err held too long");
    // Never both answers at once
    a_one_answer: assert property (!(ack_o && err_o))
        else $error("ack and err together");

    // Register content checks
    // A refused access changes no register
    a_refused_no_write: assert property (err_o
        |=> $stable(deep_gate_ff) && $stable(fault_mask_ff))
        else $error("refused access changed a register");
    // The read-only enable view ignores writes
    a_view_read_only: assert property (ack_o && we_i && adr_i == dcg_pkg::OFS_CLK_EN
        |=> deep_gate_ff == $past(deep_gate_ff))
        else $error("enable view write changed the gate word");
    // Reserved mask bits never become set
    a_mask_resv_zero: assert property ((fault_mask_ff & ~dcg_pkg::GATE_WR_MASK) == '0)
        else $error("reserved mask bit set");
    // Reserved enable positions never reach the units
    a_en_resv_zero: assert property ((unit_clk_en_o & ~dcg_pkg::GATE_WR_MASK) == '0)
        else $error("reserved enable set");
    // Gate word read back shows the stored word
    a_read_gate_word: assert property (ack_o && !we_i && adr_i == dcg_pkg::OFS_DEEP_GATE
        |-> dat_o == deep_gate_ff)
        else $error("gate word read back wrong");
    // Enable view read back shows no reserved bit
    a_read_view_resv: assert property (ack_o && !we_i && adr_i == dcg_pkg::OFS_CLK_EN
        |-> (dat_o & ~dcg_pkg::GATE_WR_MASK) == '0)
        else $error("reserved bit in enable view");
    // A write with no lane selected leaves the gate word
    a_no_lane_write: assert property (ack_o && we_i && adr_i == dcg_pkg::OFS_DEEP_GATE
        && sel_i == 4'h0 |=> $stable(deep_gate_ff))
        else $error("write without lanes changed the gate word");

    // Power selection
    // Sleep word governs enables one cycle later with automatic gating
    a_sleep_select: assert property (auto_gating_select_i
        && pwr_state_i == 2'(dcg_pkg::PWR_SLEEP)
        |=> unit_clk_en_o == ($past(sleep_gate_i) & dcg_pkg::GATE_WR_MASK))
        else $error("sleep enables not applied");
    // Run state keeps the run word even with automatic gating
    a_run_select: assert property (auto_gating_select_i
        && pwr_state_i == 2'(dcg_pkg::PWR_RUN)
        |=> unit_clk_en_o == ($past(run_gate_i) & dcg_pkg::GATE_WR_MASK))
        else $error("run enables not applied in run state");
    // Enables hold while nothing that feeds them moves, so no stray edges
    a_en_hold: assert property (!$past(rst_i) && $stable(run_gate_i) && $stable(sleep_gate_i)
        && $stable(deep_gate_ff) && $stable(auto_gating_select_i) && $stable(pwr_state_i)
        |=> $stable(unit_clk_en_o))
        else $error("enables moved without cause");

    // Fault and interrupt
    // A fault status bit only falls through a write at its offset
    a_stat_sticky: assert property (!(ack_o && we_i && adr_i == dcg_pkg::OFS_FAULT_STAT)
        |=> (fault_stat_ff & $past(fault_stat_ff)) == $past(fault_stat_ff))
        else $error("fault status fell without a clear");
    // Writing ones clears status when no fault arrives
    a_stat_w1c: assert property (ack_o && we_i && adr_i == dcg_pkg::OFS_FAULT_STAT
        && sel_i == 4'hf && fault_ff == '0
        |=> fault_stat_ff == ($past(fault_stat_ff) & ~$past(dat_i)))
        else $error("write one did not clear status");
    // A fault in the clearing cycle still sets its bit
    a_set_wins: assert property (ack_o && we_i && adr_i == dcg_pkg::OFS_FAULT_STAT
        && fault_ff != '0 |=> (fault_stat_ff & $past(fault_ff)) == $past(fault_ff))
        else $error("clear beat a new fault");
    // An unmasked fault pulse raises the interrupt next cycle
    a_irq_raise: assert property ((bus_fault_o & fault_mask_ff) != '0
        && !(ack_o && we_i && adr_i == dcg_pkg::OFS_FAULT_MASK) |=> irq_o)
        else $error("unmasked fault without interrupt");
    // With every status bit clear the interrupt is low
    a_irq_quiet: assert property (fault_stat_ff == '0 |-> !irq_o)
        else $error("interrupt without status");
    // No fault pulse without a gated request the cycle before
    a_fault_cause: assert property ((unit_req_i & ~unit_clk_en_o & dcg_pkg::GATE_WR_MASK) == '0
        |=> bus_fault_o == '0)
        else $error("fault without gated request");

    // Scenarios of interest
    c_deep_write: cover property (ack_o && we_i && adr_i == dcg_pkg::OFS_DEEP_GATE);
    c_deep_active: cover property (auto_gating_select_i
        && pwr_state_i == 2'(dcg_pkg::PWR_DEEP) && unit_clk_en_o != '0);
    c_fault_irq: cover property (|bus_fault_o ##2 irq_o);
    c_unmapped: cover property (err_o);
endmodule : dcg_clock_gate

/* File: hw/dcg_pkg.sv */
// Constants and types shared by the deep-sleep clock gate block
package dcg_pkg;
    // Bus geometry
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int SEL_W = 4;
    // Register byte offsets
    localparam logic [11:0] OFS_DEEP_GATE = 12'h128;
    localparam logic [11:0] OFS_FAULT_STAT = 12'h130;
    localparam logic [11:0] OFS_FAULT_MASK = 12'h134;
    localparam logic [11:0] OFS_CLK_EN = 12'h138;
    // Reset values and writable bits of the gate layout
    localparam logic [31:0] GATE_RESET = 32'h0000_0000;
    localparam logic [31:0] GATE_WR_MASK = 32'h5000_007f;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // Field positions
    localparam int PHY_BIT = 30;
    localparam int MAC_BIT = 28;
    localparam int PORT_LO = 0;
    localparam int PORT_HI = 6;
    // Power state of the processor
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SLEEP,
        PWR_DEEP
    } dcg_pwr_e;
endpackage : dcg_pkg

/* File: hw/dcg_sel_if.sv */
// Signals between the register front end and the enable selector
interface dcg_sel_if;
    logic [31:0] run_gate;   // Run-mode enables
    logic [31:0] sleep_gate; // Sleep-mode enables
    logic [31:0] deep_gate;  // Deep-sleep enables
    logic auto_sel;          // Automatic gating select
    logic [1:0] state;       // Raw power state code
    logic [31:0] clk_en;     // Selected unit clock enables
    modport top (
        output run_gate, sleep_gate, deep_gate, auto_sel, state,
        input clk_en
    );
    modport sel (
        input run_gate, sleep_gate, deep_gate, auto_sel, state,
        output clk_en
    );
endinterface : dcg_sel_if

/* File: hw/dcg_gate_sel.sv */
// Power-state selector producing registered unit clock enables
module dcg_gate_sel (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register side
    dcg_sel_if.sel sel_if
);
    // Combinational choice of the active gate word
    logic [31:0] nxt_clk_en;

    // Without automatic gating the run word governs every state
    always_comb begin
        nxt_clk_en = sel_if.run_gate;
        if (sel_if.auto_sel) begin
            unique case (dcg_pkg::dcg_pwr_e'(sel_if.state))
                dcg_pkg::PWR_RUN: nxt_clk_en = sel_if.run_gate;
                dcg_pkg::PWR_SLEEP: nxt_clk_en = sel_if.sleep_gate;
                dcg_pkg::PWR_DEEP: nxt_clk_en = sel_if.deep_gate;
                // Illegal code falls back to run
                default: nxt_clk_en = sel_if.run_gate;
            endcase
        end
        nxt_clk_en = nxt_clk_en & dcg_pkg::GATE_WR_MASK;
    end

    // Registered so that enables only move on a clock boundary
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_if.clk_en <= dcg_pkg::GATE_RESET;
        end else begin
            sel_if.clk_en <= nxt_clk_en;
        end
    end
endmodule : dcg_gate_sel

/* File: verification/test_deep_sleep_clock_gate_reg2.sv */
// Self-checking testbench for the deep-sleep unit clock gate register
module test_deep_sleep_clock_gate_reg2;
    timeunit 1ns;
    timeprecision 100ps;
    // Writable bits of the gate layout
    localparam logic [31:0] WM = dcg_pkg::GATE_WR_MASK;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [11:0] adr_i = 12'h000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic err_o;
    logic [31:0] run_gate_i = 32'h0;
    logic [31:0] sleep_gate_i = 32'h0;
    logic auto_gating_select_i = 1'b0;
    logic [1:0] pwr_state_i = 2'h0;
    logic [31:0] unit_clk_en_o;
    logic [31:0] unit_req_i = 32'h0;
    logic [31:0] bus_fault_o;
    logic irq_o;
    int num_errors = 0;
    int compares = 0;
    // Device under test
    dcg_clock_gate i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .err_o(err_o), .run_gate_i(run_gate_i), .sleep_gate_i(sleep_gate_i),
        .auto_gating_select_i(auto_gating_select_i), .pwr_state_i(pwr_state_i),
        .unit_clk_en_o(unit_clk_en_o), .unit_req_i(unit_req_i), .bus_fault_o(bus_fault_o),
        .irq_o(irq_o));
    // 25 MHz clock
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // Compare one word, four-state exact
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One classic Wishbone cycle; entered just after a rising edge
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic exp_e, output logic [31:0] q);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        // Values read here are those sampled at this edge
        do begin
            @(posedge clk_i);
            n++;
        end while (!(ack_o === 1'b1 || err_o === 1'b1) && n < 20);
        q = dat_o;
        chk({31'h0, err_o}, {31'h0, exp_e});
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    // Register read with expected data, skipped for refused accesses
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, 4'hf, exp_e, q);
        if (!exp_e) chk(q, exp);
    endtask : rd
    // Register write
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic exp_e);
        logic [31:0] q;
        wb(1'b1, a, d, s, exp_e, q);
    endtask : wr
    // Everything cleared after reset
    task automatic t_reset();
        chk(unit_clk_en_o, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        rd(dcg_pkg::OFS_DEEP_GATE, dcg_pkg::GATE_RESET, 1'b0);
        rd(dcg_pkg::OFS_FAULT_STAT, 32'h0, 1'b0);
        $display("t_reset done");
    endtask : t_reset
    // Walk a one through all 32 bits, only the writable ones stick
    task automatic t_layout();
        auto_gating_select_i <= 1'b1;
        pwr_state_i <= 2'h2;
        for (int i = 0; i < 32; i++) begin
            wr(dcg_pkg::OFS_DEEP_GATE, 32'h1 << i, 4'hf, 1'b0);
            rd(dcg_pkg::OFS_DEEP_GATE, (32'h1 << i) & WM, 1'b0);
            chk(unit_clk_en_o, (32'h1 << i) & WM);
        end
        wr(dcg_pkg::OFS_DEEP_GATE, 32'hffff_ffff, 4'hf, 1'b0);
        rd(dcg_pkg::OFS_DEEP_GATE, 32'h5000_007f, 1'b0);
        // Lowest byte only: upper enables must survive
        wr(dcg_pkg::OFS_DEEP_GATE, 32'h0, 4'h1, 1'b0);
        rd(dcg_pkg::OFS_DEEP_GATE, 32'h5000_0000, 1'b0);
        $display("t_layout done");
    endtask : t_layout
    // Apply a power context and check the chosen enables
    task automatic sel_case(input logic a, input logic [1:0] p, input logic [31:0] exp);
        auto_gating_select_i <= a;
        pwr_state_i <= p;
        repeat (3) @(posedge clk_i);
        chk(unit_clk_en_o, exp);
        rd(dcg_pkg::OFS_CLK_EN, exp, 1'b0);
    endtask : sel_case
    // Word selection by power state and automatic select
    task automatic t_select();
        run_gate_i <= 32'hffff_ffff;
        sleep_gate_i <= 32'h4000_0040;
        wr(dcg_pkg::OFS_DEEP_GATE, 32'h1000_0001, 4'hf, 1'b0);
        sel_case(1'b1, 2'h2, 32'h1000_0001);
        sel_case(1'b1, 2'h1, 32'h4000_0040);
        sel_case(1'b1, 2'h0, WM);
        sel_case(1'b1, 2'h3, WM);
        sel_case(1'b0, 2'h2, WM);
        sel_case(1'b1, 2'h2, 32'h1000_0001);
        $display("t_select done");
    endtask : t_select
    // Gated accesses fault, status is sticky, mask and clear drive the interrupt
    task automatic t_fault();
        wr(dcg_pkg::OFS_DEEP_GATE, 32'h0000_0001, 4'hf, 1'b0);
        wr(dcg_pkg::OFS_FAULT_MASK, 32'hffff_ffff, 4'hf, 1'b0);
        repeat (2) @(posedge clk_i);
        unit_req_i <= 32'h5000_0003;
        @(posedge clk_i);
        unit_req_i <= 32'h0;
        @(posedge clk_i);
        chk(bus_fault_o, 32'h5000_0002);
        @(posedge clk_i);
        chk(bus_fault_o, 32'h0);
        rd(dcg_pkg::OFS_FAULT_STAT, 32'h5000_0002, 1'b0);
        chk({31'h0, irq_o}, 32'h1);
        wr(dcg_pkg::OFS_FAULT_MASK, 32'h0, 4'hf, 1'b0);
        chk({31'h0, irq_o}, 32'h0);
        wr(dcg_pkg::OFS_FAULT_MASK, 32'hffff_ffff, 4'hf, 1'b0);
        wr(dcg_pkg::OFS_FAULT_STAT, 32'h4000_0000, 4'hf, 1'b0);
        rd(dcg_pkg::OFS_FAULT_STAT, 32'h1000_0002, 1'b0);
        wr(dcg_pkg::OFS_FAULT_STAT, 32'h1000_0002, 4'hf, 1'b0);
        chk({31'h0, irq_o}, 32'h0);
        $display("t_fault done");
    endtask : t_fault
    // Unmapped and read-only places leave the gate word alone
    task automatic t_refuse();
        rd(12'h12c, 32'h0, 1'b1);
        wr(12'h140, 32'hffff_ffff, 4'hf, 1'b1);
        wr(dcg_pkg::OFS_CLK_EN, 32'hffff_ffff, 4'hf, 1'b0);
        rd(dcg_pkg::OFS_DEEP_GATE, 32'h0000_0001, 1'b0);
        $display("t_refuse done");
    endtask : t_refuse
    // Verdict and end of run
    task automatic end_of_test();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    // Watchdog: the tests need well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        end_of_test();
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        t_reset();
        t_layout();
        t_select();
        t_fault();
        t_refuse();
        end_of_test();
    end
endmodule : test_deep_sleep_clock_gate_reg2
